// [core/adchp_top.sv]
// How it works
// - result register holds 13-bit two's complement, 12-bit magnitude plus sign
// - every host read drives the result, never the configuration
// - narrow high byte carries the sign replicated above bit 12
// - bit 12 is sign, bits 11..0 the value, bit 11 most significant
// - result reads zero after power-up until a conversion completes
// - bus_width_select clear drives lines 7..0 only; set drives 12..0
// - narrow bus width is selected at power-up
// - narrow mode loads the whole configuration from one write
// - narrow reads alternate low byte then high byte
// - wide mode moves the full result or configuration in one cycle
// - write_edge_select high latches on falling write edge, low on rising
// - standby command enters standby; ready_low_flag stays high there
// - any other command leaves standby; ready_low_flag drops at once, except full cal and auto-zero, which keep it high while calibrating
// - device is in standby after power-up
// - sync bit set makes trigger pin an input; set at power-up
// - external trigger mode starts conversion on trigger rising edge
// - internal mode drives trigger pin high during conversion only
// - internal acquisition counts 9, 15, 47 or 79 clocks
// - acquisition counter starts when ready_low_flag rises after a read
// - external mode ignores acquisition select; trigger rise ends acquisition
// - full calibration averages eight offset measurements into a coefficient
// - configuration is 8-bit write-only and never readable
// - acquisition select codes 00..11 give 9, 15, 47, 79 clocks
// - command codes: standby, full cal, auto-zero, reset, start conversion
// - sync bit is bit 4 and configuration resets to 0x10
module adchp_top #(
   parameter int unsigned CONV_CYCLES = 40,
   parameter int unsigned CAL_CYCLES = 200,
   parameter int unsigned FIFO_DEPTH = 16
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire adchp_pkg::adchp_bus_t host_bus,
   input wire logic write_edge_select,
   input wire logic [12:0] data_in,
   output logic [12:0] data_out,
   output logic [12:0] data_oe,
   output logic ready_low_flag,
   input wire logic sample_trigger_in,
   output logic sample_trigger_out,
   output logic sample_trigger_oe,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic [12:0] sample_data
);
   generate
      if (CONV_CYCLES < 1 || CONV_CYCLES >= (1 << adchp_pkg::CNT_W) ||
          CAL_CYCLES < 1 || CAL_CYCLES >= (1 << adchp_pkg::CNT_W)) begin : g_bad
         $error("conversion and calibration cycles must fit the counter");
      end
   endgenerate

   localparam logic [15:0] CONV_LEN = 16'(CONV_CYCLES);
   localparam logic [15:0] CAL_LEN = 16'(CAL_CYCLES);

   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_IDLE,
      ST_ACQ,
      ST_WAIT_TRIG,
      ST_CONVERT,
      ST_CAL
   } adchp_state_t;

   adchp_state_t state_r;
   adchp_state_t state_nxt;
   adchp_pkg::adchp_cfg_t cfg_r;
   adchp_pkg::adchp_cfg_t cfg_new;
   adchp_pkg::adchp_bus_t bus_d_r;
   logic [12:0] result_r;
   logic [12:0] offset_r;
   logic [15:0] cal_sum_r;
   logic [3:0] cal_left_r;
   logic cal_full_r;
   logic byte_sel_r;
   logic edge_sel_r;
   logic strap_taken_r;
   logic trig_d_r;
   logic [12:0] data_out_r;
   logic [12:0] data_oe_r;
   logic ready_r;
   logic trig_out_r;
   logic trig_oe_r;

   logic wr_fall;
   logic wr_rise;
   logic cfg_write;
   logic rd_act;
   logic rd_end;
   logic read_done;
   logic trig_rise;
   logic acq_start;
   logic acq_busy;
   logic acq_done;
   logic run_start;
   logic run_busy;
   logic [15:0] run_len;
   logic fifo_valid;
   logic fifo_pop;
   logic [12:0] fifo_data;
   logic [12:0] corrected;
   logic [15:0] sum_nxt;

   // strap is caught once after reset release; it must not move afterwards
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         edge_sel_r <= 1'b0;
         strap_taken_r <= 1'b0;
      end else if (!strap_taken_r) begin
         edge_sel_r <= write_edge_select;
         strap_taken_r <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bus_d_r <= '1;
         trig_d_r <= 1'b0;
      end else begin
         bus_d_r <= host_bus;
         trig_d_r <= sample_trigger_in;
      end
   end

   assign wr_fall = bus_d_r.wr_n && !host_bus.wr_n && !host_bus.cs_n;
   assign wr_rise = !bus_d_r.wr_n && host_bus.wr_n && !bus_d_r.cs_n;
   assign cfg_write = strap_taken_r && (edge_sel_r ? wr_fall : wr_rise);
   // only the low byte matters even on a wide bus
   assign cfg_new = adchp_pkg::adchp_cfg_t'(data_in[7:0]);
   assign rd_act = !host_bus.cs_n && !host_bus.rd_n;
   assign rd_end = !bus_d_r.rd_n && host_bus.rd_n && !bus_d_r.cs_n;
   assign read_done = rd_end && (cfg_r.bus_wide || byte_sel_r);
   assign trig_rise = cfg_r.sync && sample_trigger_in && !trig_d_r;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r <= adchp_pkg::CFG_RESET;
      end else if (cfg_write) begin
         cfg_r <= cfg_new;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         byte_sel_r <= 1'b0;
      end else if (cfg_r.bus_wide || cfg_write) begin
         byte_sel_r <= 1'b0;
      end else if (rd_end) begin
         byte_sel_r <= !byte_sel_r;
      end
   end

   always_comb begin
      state_nxt = state_r;
      acq_start = 1'b0;
      run_start = 1'b0;
      run_len = CONV_LEN;
      if (cfg_write) begin
         unique case (cfg_new.cmd)
            adchp_pkg::CMD_STANDBY: state_nxt = ST_STANDBY;
            adchp_pkg::CMD_FULL_CAL, adchp_pkg::CMD_AUTO_ZERO: begin
               state_nxt = ST_CAL;
               run_start = 1'b1;
               run_len = CAL_LEN;
            end
            adchp_pkg::CMD_START: begin
               state_nxt = cfg_new.sync ? ST_WAIT_TRIG : ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
         endcase
      end else begin
         unique case (state_r)
            ST_STANDBY: state_nxt = ST_STANDBY;
            ST_IDLE: begin
               if (read_done && !cfg_r.sync &&
                   cfg_r.cmd == adchp_pkg::CMD_START) begin
                  state_nxt = ST_ACQ;
                  acq_start = 1'b1;
               end
            end
            ST_ACQ: begin
               if (acq_done) begin
                  state_nxt = ST_CONVERT;
                  run_start = 1'b1;
               end
            end
            ST_WAIT_TRIG: begin
               if (trig_rise) begin
                  state_nxt = ST_CONVERT;
                  run_start = 1'b1;
               end
            end
            ST_CONVERT: begin
               if (!run_busy && fifo_valid) begin
                  state_nxt = cfg_r.sync ? ST_WAIT_TRIG : ST_IDLE;
               end
            end
            ST_CAL: begin
               if (!run_busy && cal_left_r == 4'h0) begin
                  state_nxt = ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_STANDBY;
      end else begin
         state_r <= state_nxt;
      end
   end

   // acquisition length ignores acq select in external mode since
   // that path never starts this timer
   adchp_countdown #(.W(adchp_pkg::CNT_W)) u_acq (
      .clock(clock),
      .arst_n(arst_n),
      .start(acq_start),
      .length({9'h000, adchp_pkg::adchp_acq_len(cfg_r.acq_sel)}),
      .busy(acq_busy),
      .done(acq_done)
   );

   adchp_countdown #(.W(adchp_pkg::CNT_W)) u_run (
      .clock(clock),
      .arst_n(arst_n),
      .start(run_start),
      .length(run_len),
      .busy(run_busy),
      .done()
   );

   // samples from the front end queue here; a conversion or calibration
   // that finds it empty waits; the front end sees back-pressure once it is full
   adchp_fifo #(.WIDTH(adchp_pkg::RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .arst_n(arst_n),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(sample_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   assign fifo_pop = fifo_valid &&
      ((state_r == ST_CONVERT && !run_busy && !cfg_write) ||
       (state_r == ST_CAL && cal_left_r != 4'h0));

   // offset subtraction wraps rather than saturates
   assign corrected = 13'(fifo_data - offset_r);
   assign sum_nxt = 16'(cal_sum_r + {{3{fifo_data[adchp_pkg::SIGN_BIT]}},
                                      fifo_data});

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cal_left_r <= 4'h0;
         cal_full_r <= 1'b0;
         cal_sum_r <= '0;
         offset_r <= adchp_pkg::OFFSET_RESET;
      end else if (run_start && state_nxt == ST_CAL) begin
         cal_full_r <= (cfg_new.cmd == adchp_pkg::CMD_FULL_CAL);
         cal_left_r <= (cfg_new.cmd == adchp_pkg::CMD_FULL_CAL) ?
                       adchp_pkg::CAL_SAMPLES : adchp_pkg::AZ_SAMPLES;
         cal_sum_r <= '0;
      end else if (state_r == ST_CAL && fifo_pop) begin
         cal_left_r <= 4'(cal_left_r - 1'b1);
         cal_sum_r <= sum_nxt;
         if (cal_left_r == 4'h1) begin
            offset_r <= cal_full_r ?
               13'($signed(sum_nxt) >>> adchp_pkg::CAL_SHIFT) :
               sum_nxt[12:0];
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         result_r <= adchp_pkg::RESULT_RESET;
      end else if (state_r == ST_CONVERT && fifo_pop) begin
         if (cfg_r.single_ended && corrected[adchp_pkg::SIGN_BIT]) begin
            result_r <= adchp_pkg::RESULT_RESET;
         end else begin
            result_r <= corrected;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         data_out_r <= adchp_pkg::RESULT_RESET;
         data_oe_r <= adchp_pkg::OE_OFF;
      end else if (rd_act) begin
         if (cfg_r.bus_wide) begin
            data_out_r <= result_r;
            data_oe_r <= adchp_pkg::OE_WIDE;
         end else begin
            data_out_r <= {5'h00, byte_sel_r ?
               adchp_pkg::adchp_high_byte(result_r) : result_r[7:0]};
            data_oe_r <= adchp_pkg::OE_NARROW;
         end
      end else begin
         data_out_r <= adchp_pkg::RESULT_RESET;
         data_oe_r <= adchp_pkg::OE_OFF;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ready_r <= 1'b1;
         trig_out_r <= 1'b0;
         trig_oe_r <= 1'b0;
      end else begin
         ready_r <= (state_nxt == ST_STANDBY) || (state_nxt == ST_ACQ) ||
                    (state_nxt == ST_CONVERT) || (state_nxt == ST_CAL);
         trig_out_r <= (state_nxt == ST_CONVERT);
         trig_oe_r <= !cfg_r.sync;
      end
   end

   assign data_out = data_out_r;
   assign data_oe = data_oe_r;
   assign ready_low_flag = ready_r;
   assign sample_trigger_out = trig_out_r;
   assign sample_trigger_oe = trig_oe_r;

   // helper: cycles spent in acquisition
   logic [7:0] acq_run_r;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         acq_run_r <= 8'h00;
      end else begin
         acq_run_r <= (state_r == ST_ACQ) ? 8'(acq_run_r + 1'b1) : 8'h00;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   standby_ready_a: assert property (
      state_r == ST_STANDBY |-> ready_low_flag)
      else $error("ready low while in standby");

   leave_standby_a: assert property (
      state_r == ST_STANDBY && cfg_write &&
      (cfg_new.cmd == adchp_pkg::CMD_RESET ||
       cfg_new.cmd == adchp_pkg::CMD_START) |=> !ready_low_flag)
      else $error("ready did not drop on leaving standby");

   narrow_pins_a: assert property (
      !cfg_r.bus_wide |=> data_oe[12:8] == 5'h00)
      else $error("upper data lines driven in narrow mode");

   read_only_a: assert property (
      rd_act && cfg_r.bus_wide |=> data_out == $past(result_r))
      else $error("wide read did not return result");

   high_byte_a: assert property (
      rd_act && !cfg_r.bus_wide && byte_sel_r |=>
      data_out[7:5] == {3{$past(result_r[12])}} && data_oe == 13'h00FF)
      else $error("high byte sign not extended");

   byte_toggle_a: assert property (
      rd_end && !cfg_r.bus_wide && !cfg_write |=>
      byte_sel_r != $past(byte_sel_r))
      else $error("narrow read did not alternate bytes");

   acq_length_a: assert property (
      state_r == ST_ACQ && state_nxt == ST_CONVERT |->
      acq_run_r == 8'(adchp_pkg::adchp_acq_len(cfg_r.acq_sel) - 1'b1))
      else $error("acquisition length wrong");

   acq_start_a: assert property (
      state_r == ST_IDLE && state_nxt == ST_ACQ |=>
      ready_low_flag && acq_busy)
      else $error("acquisition did not start with ready high");

   ext_start_a: assert property (
      state_r == ST_WAIT_TRIG && trig_rise && !cfg_write |=>
      state_r == ST_CONVERT ##1 ready_low_flag)
      else $error("trigger edge did not start conversion");

   trig_drive_a: assert property (
      sample_trigger_out |-> state_r == ST_CONVERT && ready_low_flag)
      else $error("trigger pin high outside conversion");

endmodule // adchp_top

// [core/adchp_pkg.sv]
package adchp_pkg;

   localparam int RES_W = 13;
   localparam int CFG_W = 8;
   localparam int BYTE_W = 8;
   localparam int SIGN_BIT = 12;
   localparam int SUM_W = 16;
   localparam int CNT_W = 16;

   // power-up values
   localparam logic [7:0] CFG_RESET = 8'h10;
   localparam logic [12:0] RESULT_RESET = 13'h0000;
   localparam logic [12:0] OFFSET_RESET = 13'h0000;

   // data pin enables per bus width
   localparam logic [12:0] OE_WIDE = 13'h1FFF;
   localparam logic [12:0] OE_NARROW = 13'h00FF;
   localparam logic [12:0] OE_OFF = 13'h0000;

   // command field codes
   localparam logic [2:0] CMD_STANDBY = 3'h0;
   localparam logic [2:0] CMD_FULL_CAL = 3'h1;
   localparam logic [2:0] CMD_AUTO_ZERO = 3'h2;
   localparam logic [2:0] CMD_RESET = 3'h3;
   localparam logic [2:0] CMD_START = 3'h4;

   // acquisition lengths in device clocks
   localparam logic [6:0] ACQ_LEN_0 = 7'h09;
   localparam logic [6:0] ACQ_LEN_1 = 7'h0F;
   localparam logic [6:0] ACQ_LEN_2 = 7'h2F;
   localparam logic [6:0] ACQ_LEN_3 = 7'h4F;

   // offset measurements per calibration kind
   localparam logic [3:0] CAL_SAMPLES = 4'h8;
   localparam logic [3:0] AZ_SAMPLES = 4'h1;
   localparam int CAL_SHIFT = 3;

   typedef struct packed {
      logic [2:0] cmd;
      logic sync;
      logic bus_wide;
      logic single_ended;
      logic [1:0] acq_sel;
   } adchp_cfg_t;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
   } adchp_bus_t;

   function automatic logic [6:0] adchp_acq_len(input logic [1:0] sel);
      logic [6:0] len;
      len = ACQ_LEN_0;
      unique case (sel)
         2'h0: len = ACQ_LEN_0;
         2'h1: len = ACQ_LEN_1;
         2'h2: len = ACQ_LEN_2;
         2'h3: len = ACQ_LEN_3;
      endcase
      return len;
   endfunction

   function automatic logic [7:0] adchp_high_byte(input logic [12:0] r);
      return {{3{r[SIGN_BIT]}}, r[12:8]};
   endfunction

endpackage

// [core/adchp_countdown.sv]
module adchp_countdown #(
   parameter int W = 16
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic start,
   input wire logic [W-1:0] length,
   output logic busy,
   output logic done
);
   logic [W-1:0] cnt_r;
   logic busy_r;

   // length of zero is treated as one cycle
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
         busy_r <= 1'b0;
      end else if (start) begin
         cnt_r <= (length == '0) ? '0 : W'(length - 1'b1);
         busy_r <= 1'b1;
      end else if (busy_r) begin
         if (cnt_r == '0) begin
            busy_r <= 1'b0;
         end else begin
            cnt_r <= W'(cnt_r - 1'b1);
         end
      end
   end

   assign busy = busy_r;
   assign done = busy_r && (cnt_r == '0);
endmodule // adchp_countdown

// [core/adchp_fifo.sv]
module adchp_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
         $error("fifo depth must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   logic push;
   logic pop;
   logic in_ready_r;
   logic [AW:0] wr_ptr_nxt;
   logic [AW:0] rd_ptr_nxt;

   // room is registered so the front end sees a flop, not pointer logic
   assign in_ready = in_ready_r;
   assign wr_ptr_nxt = push ? (AW+1)'(wr_ptr_r + 1'b1) : wr_ptr_r;
   assign rd_ptr_nxt = pop ? (AW+1)'(rd_ptr_r + 1'b1) : rd_ptr_r;
   assign out_valid = (wr_ptr_r != rd_ptr_r);
   assign out_data = mem[rd_ptr_r[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         in_ready_r <= 1'b1;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         in_ready_r <= (wr_ptr_nxt[AW] == rd_ptr_nxt[AW]) ||
                       (wr_ptr_nxt[AW-1:0] != rd_ptr_nxt[AW-1:0]);
      end
   end
endmodule // adchp_fifo

// [tb/adchp_host_model.sv]
module adchp_host_model (
   input wire logic clock,
   output adchp_pkg::adchp_bus_t host_bus,
   output logic [12:0] data_in,
   input wire logic [12:0] data_out,
   input wire logic [12:0] data_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [12:0] drv_r;

   initial begin
      host_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
      drv_r = 13'h1FFF;
   end

   // a released line shows the inverse of its last value, never a stale copy
   assign data_in = (data_out & data_oe) | (drv_r & ~data_oe);

   task automatic step();
      @(posedge clock);
      #1;
   endtask

   // data stands across both write edges, so either strap setting latches it
   task automatic write_cfg(input logic [7:0] val);
      host_bus.cs_n = 1'b0;
      drv_r = {5'h00, val};
      step();
      host_bus.wr_n = 1'b0;
      step();
      step();
      host_bus.wr_n = 1'b1;
      step();
      host_bus.cs_n = 1'b1;
      drv_r = ~drv_r;
      step();
   endtask

   task automatic read_bus(output logic [12:0] val, output logic [12:0] oe);
      host_bus.cs_n = 1'b0;
      host_bus.rd_n = 1'b0;
      step();
      step();
      val = data_out;
      oe = data_oe;
      host_bus.rd_n = 1'b1;
      step();
      host_bus.cs_n = 1'b1;
      step();
      step();
   endtask
endmodule // adchp_host_model

// [tb/adc_host_port_control_test.sv]
module adc_host_port_control_test;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int CONV = 2;
   localparam int CAL = 4;

   logic clock;
   logic arst_n;
   logic strap;
   adchp_pkg::adchp_bus_t host_bus;
   logic [12:0] data_in, data_out, data_oe;
   logic ready_low_flag, trig_out, trig_oe, trig_in;
   logic trig_drv;
   logic sample_valid;
   logic sample_ready;
   logic [12:0] sample_data;
   logic [12:0] rd_val, rd_oe;
   int num_errors = 0;
   int cmp_count = 0;
   int n_acq [4];
   int lens [4] = '{9, 15, 47, 79};

   always #20 clock = ~clock;

   // trigger pin level: the device wins while it drives the pin
   assign trig_in = trig_oe ? trig_out : trig_drv;

   adchp_top #(.CONV_CYCLES(CONV), .CAL_CYCLES(CAL), .FIFO_DEPTH(16))
   u_adchp_top (
      .clock(clock), .arst_n(arst_n), .host_bus(host_bus),
      .write_edge_select(strap), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .ready_low_flag(ready_low_flag),
      .sample_trigger_in(trig_in), .sample_trigger_out(trig_out),
      .sample_trigger_oe(trig_oe), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .sample_data(sample_data)
   );

   adchp_host_model u_adchp_host_model (
      .clock(clock), .host_bus(host_bus), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe)
   );

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons=%0d errors=%0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic step();
      @(posedge clock);
      #1;
   endtask

   task automatic wait_ready(input logic v, input int bound);
      int i;
      i = 0;
      while (ready_low_flag !== v && i < bound) begin
         step();
         i++;
      end
      if (ready_low_flag !== v) begin
         check(ready_low_flag, v);
         finish_test();
      end
   endtask

   task automatic push_sample(input logic [12:0] v);
      int i;
      i = 0;
      sample_valid = 1'b1;
      sample_data = v;
      while (sample_ready !== 1'b1 && i < 300) begin
         step();
         i++;
      end
      if (sample_ready !== 1'b1) begin
         check(sample_ready, 1'b1);
         finish_test();
      end
      step();
      sample_valid = 1'b0;
      sample_data = ~v;
   endtask

   task automatic do_reset(input logic edge_sel);
      arst_n = 1'b0;
      strap = edge_sel;
      repeat (6) step();
      arst_n = 1'b1;
      repeat (3) step();
   endtask

   task automatic rd_check(input logic [12:0] exp);
      u_adchp_host_model.read_bus(rd_val, rd_oe);
      check(rd_val, exp);
   endtask

   task automatic t_powerup();
      check(ready_low_flag, 1'b1);
      check(trig_oe, 1'b0);
      u_adchp_host_model.read_bus(rd_val, rd_oe);
      check(rd_oe, adchp_pkg::OE_NARROW);
      check(rd_val[7:0], 8'h00);
      u_adchp_host_model.read_bus(rd_val, rd_oe);
      check(rd_val[7:0], 8'h00);
      u_adchp_host_model.write_cfg(8'h10);
      repeat (20) step();
      check(ready_low_flag, 1'b1);
   endtask

   task automatic t_ext_conv();
      push_sample(13'h1ABC);
      u_adchp_host_model.write_cfg(8'h90);
      wait_ready(1'b0, 3);
      repeat (4) step();
      check(ready_low_flag, 1'b0);
      trig_drv = 1'b1;
      wait_ready(1'b1, 5);
      repeat (3) step();
      trig_drv = 1'b0;
      wait_ready(1'b0, 30);
      u_adchp_host_model.read_bus(rd_val, rd_oe);
      check(rd_val[7:0], 8'hBC);
      u_adchp_host_model.read_bus(rd_val, rd_oe);
      check(rd_val[7:0], 8'hFA);
   endtask

   task automatic t_acq();
      logic [12:0] prev;
      int n;
      prev = 13'h1ABC;
      for (int k = 0; k < 4; k++) begin
         push_sample(13'h0123 + 13'(k));
         u_adchp_host_model.write_cfg(8'h88 | 8'(k));
         wait_ready(1'b0, 3);
         check(trig_oe, 1'b1);
         u_adchp_host_model.read_bus(rd_val, rd_oe);
         check(rd_oe, adchp_pkg::OE_WIDE);
         check(rd_val, prev);
         n = 0;
         while (trig_out !== 1'b1 && n < 200) begin
            step();
            n++;
         end
         if (trig_out !== 1'b1) begin
            check(trig_out, 1'b1);
            finish_test();
         end
         n_acq[k] = n;
         check(ready_low_flag, 1'b1);
         wait_ready(1'b0, 30);
         check(trig_out, 1'b0);
         prev = 13'h0123 + 13'(k);
      end
      // fixed bus latency cancels in the differences
      for (int k = 1; k < 4; k++) begin
         check(16'(n_acq[k] - n_acq[0]), 16'(lens[k] - lens[0]));
      end
      rd_check(prev);
   endtask

   task automatic conv_wide(input logic [12:0] s, input logic [12:0] prev,
                            input logic [12:0] exp, input logic [7:0] cfg);
      // sample goes in after the write so no pending conversion takes it
      u_adchp_host_model.write_cfg(cfg);
      wait_ready(1'b0, 3);
      push_sample(s);
      rd_check(prev);
      wait_ready(1'b0, 200);
      rd_check(exp);
   endtask

   task automatic t_cal();
      u_adchp_host_model.write_cfg(8'h28);
      check(ready_low_flag, 1'b1);
      // alternating offsets average to 0x10; a single take would give 0x08
      for (int i = 0; i < 8; i++) begin
         push_sample(i[0] ? 13'h0018 : 13'h0008);
      end
      wait_ready(1'b0, 100);
      conv_wide(13'h0100, 13'h0126, 13'h00F0, 8'h88);
      u_adchp_host_model.write_cfg(8'h48);
      check(ready_low_flag, 1'b1);
      push_sample(13'h0030);
      wait_ready(1'b0, 100);
      u_adchp_host_model.write_cfg(8'h68);
      repeat (4) step();
      check(ready_low_flag, 1'b0);
      conv_wide(13'h0100, 13'h00F0, 13'h00D0, 8'h88);
      // single-ended setting turns a negative result into zero
      conv_wide(13'h0010, 13'h00D0, 13'h0000, 8'h8C);
   endtask

   task automatic t_fill();
      u_adchp_host_model.write_cfg(8'h18);
      for (int i = 0; i < 16; i++) begin
         push_sample(13'(i));
      end
      check(sample_ready, 1'b0);
      u_adchp_host_model.write_cfg(8'h88);
      wait_ready(1'b0, 3);
      for (int i = 0; i < 17; i++) begin
         u_adchp_host_model.read_bus(rd_val, rd_oe);
         if (i > 0) begin
            check(rd_val, 13'(13'(i - 1) - 13'h0030));
         end
         if (i < 16) begin
            wait_ready(1'b0, 200);
         end
      end
      check(sample_ready, 1'b1);
   endtask

   task automatic t_strap();
      do_reset(1'b0);
      check(ready_low_flag, 1'b1);
      u_adchp_host_model.write_cfg(8'h98);
      u_adchp_host_model.read_bus(rd_val, rd_oe);
      check(rd_oe, adchp_pkg::OE_WIDE);
      check(rd_val, adchp_pkg::RESULT_RESET);
   endtask

   initial begin
      clock = 1'b0;
      arst_n = 1'b0;
      strap = 1'b1;
      trig_drv = 1'b0;
      sample_valid = 1'b0;
      sample_data = 13'h0000;
      do_reset(1'b1);
      t_powerup();
      t_ext_conv();
      t_acq();
      t_cal();
      t_fill();
      t_strap();
      finish_test();
   end
endmodule // adc_host_port_control_test
